// ==== hdl/pixel_out_pkg.sv ====
package pixel_out_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PIX_W = 10;
   localparam int ROW_W = 11;
   localparam int KERN_W = 8;
   localparam int COL_W = 12;
   localparam int CNT_W = 16;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_REGION0_ROWS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_REGION1_ROWS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_REGION0_COLS = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_REGION1_COLS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_OVERHEAD = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_BLACK_LINES = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_TRAINING = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;

   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_SUBSAMPLE = 1;
   localparam int CTRL_COLOUR = 2;
   localparam int CTRL_CRC_SEED = 3;
   localparam int CTRL_BLACK_ROW_FRAME_FLAG_ON = 4;
   localparam int CTRL_BLACK_ROW_ROW_FLAG_ON = 5;
   localparam int CTRL_W = 6;

   localparam int FIRST_LSB = 0;
   localparam int LAST_LSB = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_BLACK = 1;
   localparam int STAT_FRAME = 2;
   localparam int STAT_COUNT_LSB = 16;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h30;
   localparam logic [ROW_W-1:0] REGION0_FIRST_RESET = 11'h000;
   localparam logic [ROW_W-1:0] REGION0_LAST_RESET = 11'h009;
   localparam logic [ROW_W-1:0] REGION1_FIRST_RESET = 11'h005;
   localparam logic [ROW_W-1:0] REGION1_LAST_RESET = 11'h00E;
   localparam logic [KERN_W-1:0] REGION0_XFIRST_RESET = 8'h00;
   localparam logic [KERN_W-1:0] REGION0_XLAST_RESET = 8'h01;
   localparam logic [KERN_W-1:0] REGION1_XFIRST_RESET = 8'h02;
   localparam logic [KERN_W-1:0] REGION1_XLAST_RESET = 8'h03;
   localparam logic [CNT_W-1:0] FRAME_OVERHEAD_RESET = 16'h0008;
   localparam logic [CNT_W-1:0] ROW_OVERHEAD_RESET = 16'h0004;
   localparam logic [KERN_W-1:0] BLACK_LINES_RESET = 8'h02;
   localparam logic [PIX_W-1:0] TRAINING_RESET = 10'h3A6;

   localparam logic [PIX_W-1:0] CRC_POLY = 10'h24F;
   localparam logic [2:0] KERNEL_LAST = 3'h7;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_FOT = 5'b00010,
      ST_ROT = 5'b00100,
      ST_PIX = 5'b01000,
      ST_CRC = 5'b10000
   } state_t;

endpackage

// ==== hdl/line_crc.sv ====
module line_crc
   import pixel_out_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic init,
   input wire logic seed_ones,
   input wire logic upd,
   input wire logic [PIX_W-1:0] data,
   // Result.
   output logic [PIX_W-1:0] crc
);

   typedef struct packed {
      logic [PIX_W-1:0] crc;
   } crc_state_t;

   crc_state_t q_r, q_nxt;

   function automatic logic [PIX_W-1:0] crc_step(input logic [PIX_W-1:0] c,
                                                 input logic [PIX_W-1:0] d);
      logic [PIX_W-1:0] r;
      logic fb;
      r = c;
      for (int i = PIX_W - 1; i >= 0; i--) begin
         fb = r[PIX_W-1] ^ d[i];
         r = {r[PIX_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
      return r;
   endfunction

   always_comb begin
      q_nxt = q_r;
      if (init) begin
         q_nxt.crc = seed_ones ? '1 : '0;
      end else if (upd) begin
         q_nxt.crc = crc_step(q_r.crc, data);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign crc = q_r.crc;

endmodule

// ==== hdl/pixel_out.sv ====
// Chosen here: register access over APB and the register addresses.
module pixel_out
   import pixel_out_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link clock from outside.
   input wire logic link_clk,
   // Pixel array read port.
   output logic [ROW_W-1:0] pix_row,
   output logic [COL_W-1:0] pix_col,
   output logic pix_black,
   input wire logic [PIX_W-1:0] pix_data,
   // Parallel pixel output.
   output logic out_clk,
   output logic frame_strobe,
   output logic row_strobe,
   output logic [PIX_W-1:0] out_data
);

   typedef struct packed {
      state_t st;
      logic s1;
      logic s2;
      logic s3;
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
      logic [CTRL_W-1:0] ctrl;
      logic [ROW_W-1:0] region0_first_row;
      logic [ROW_W-1:0] region0_last_row;
      logic [ROW_W-1:0] region1_first_row;
      logic [ROW_W-1:0] region1_last_row;
      logic [KERN_W-1:0] x0_first;
      logic [KERN_W-1:0] x0_last;
      logic [KERN_W-1:0] x1_first;
      logic [KERN_W-1:0] x1_last;
      logic [CNT_W-1:0] frame_overhead_time;
      logic [CNT_W-1:0] row_overhead_time;
      logic [KERN_W-1:0] black_lines;
      logic [PIX_W-1:0] train;
      logic f_sub;
      logic f_col;
      logic f_seed;
      logic f_bf;
      logic f_bl;
      logic blk;
      logic [KERN_W-1:0] blk_idx;
      logic [ROW_W-1:0] row;
      logic seg;
      logic [KERN_W-1:0] kern;
      logic [2:0] sub;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] frames;
      logic [PIX_W-1:0] dout;
      logic fv;
      logic lv;
      logic clk_out;
      logic [ROW_W-1:0] prow;
      logic [COL_W-1:0] pcol;
      logic pblk;
   } core_t;

   localparam core_t CORE_RESET = '{
      st: ST_IDLE,
      ctrl: CTRL_RESET,
      region0_first_row: REGION0_FIRST_RESET,
      region0_last_row: REGION0_LAST_RESET,
      region1_first_row: REGION1_FIRST_RESET,
      region1_last_row: REGION1_LAST_RESET,
      x0_first: REGION0_XFIRST_RESET,
      x0_last: REGION0_XLAST_RESET,
      x1_first: REGION1_XFIRST_RESET,
      x1_last: REGION1_XLAST_RESET,
      frame_overhead_time: FRAME_OVERHEAD_RESET,
      row_overhead_time: ROW_OVERHEAD_RESET,
      black_lines: BLACK_LINES_RESET,
      train: TRAINING_RESET,
      dout: TRAINING_RESET,
      default: '0
   };

   core_t q_r, q_nxt;
   logic step;
   logic in0;
   logic in1;
   logic crc_init;
   logic crc_upd;
   logic [ROW_W-1:0] first_all;
   logic [ROW_W-1:0] last_all;
   logic [KERN_W:0] next_kern;
   logic [KERN_W-1:0] seg_last;
   logic [PIX_W-1:0] crc_val;
   logic [DATA_W-1:0] rd_word;
   logic rd_ok;

   function automatic logic in_rows(input logic [ROW_W-1:0] r, input logic [ROW_W-1:0] f,
                                    input logic [ROW_W-1:0] l);
      return (r >= f) && (r <= l);
   endfunction

   function automatic logic count_done(input logic [CNT_W-1:0] c,
                                       input logic [CNT_W-1:0] lim);
      return (lim == '0) || (c >= lim - 16'h0001);
   endfunction

   // Position of the next pixel inside its plain or combined kernel.
   function automatic logic [3:0] pix_off(input logic [2:0] s, input logic odd,
                                          input logic ss, input logic colour);
      if (!ss) begin
         return odd ? {1'b0, KERNEL_LAST - s} : {1'b0, s};
      end else if (!colour) begin
         return {s, 1'b0};
      end else begin
         return {s[2:1], 1'b0, s[0]};
      end
   endfunction

   line_crc u_crc (
      .pclk(pclk),
      .presetn(presetn),
      .init(crc_init),
      .seed_ones(q_r.f_seed),
      .upd(crc_upd),
      .data(pix_data),
      .crc(crc_val)
   );

   // Register read decode.
   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      if (paddr == ADDR_CTRL) begin
         rd_word[CTRL_W-1:0] = q_r.ctrl;
      end else if (paddr == ADDR_REGION0_ROWS) begin
         rd_word[FIRST_LSB +: ROW_W] = q_r.region0_first_row;
         rd_word[LAST_LSB +: ROW_W] = q_r.region0_last_row;
      end else if (paddr == ADDR_REGION1_ROWS) begin
         rd_word[FIRST_LSB +: ROW_W] = q_r.region1_first_row;
         rd_word[LAST_LSB +: ROW_W] = q_r.region1_last_row;
      end else if (paddr == ADDR_REGION0_COLS) begin
         rd_word[FIRST_LSB +: KERN_W] = q_r.x0_first;
         rd_word[LAST_LSB +: KERN_W] = q_r.x0_last;
      end else if (paddr == ADDR_REGION1_COLS) begin
         rd_word[FIRST_LSB +: KERN_W] = q_r.x1_first;
         rd_word[LAST_LSB +: KERN_W] = q_r.x1_last;
      end else if (paddr == ADDR_OVERHEAD) begin
         rd_word[FIRST_LSB +: CNT_W] = q_r.frame_overhead_time;
         rd_word[LAST_LSB +: CNT_W] = q_r.row_overhead_time;
      end else if (paddr == ADDR_BLACK_LINES) begin
         rd_word[KERN_W-1:0] = q_r.black_lines;
      end else if (paddr == ADDR_TRAINING) begin
         rd_word[PIX_W-1:0] = q_r.train;
      end else if (paddr == ADDR_STATUS) begin
         rd_word[STAT_BUSY] = (q_r.st != ST_IDLE);
         rd_word[STAT_BLACK] = q_r.blk;
         rd_word[STAT_FRAME] = q_r.fv;
         rd_word[STAT_COUNT_LSB +: CNT_W] = q_r.frames;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_comb begin
      q_nxt = q_r;
      crc_init = 1'b0;
      crc_upd = 1'b0;
      next_kern = '0;
      seg_last = '0;

      // Link clock passes two flops; data moves on its falling edge.
      q_nxt.s1 = link_clk;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      q_nxt.clk_out = q_r.s2;
      step = q_r.s3 & ~q_r.s2;

      first_all = (q_r.region0_first_row < q_r.region1_first_row) ?
                  q_r.region0_first_row : q_r.region1_first_row;
      last_all = (q_r.region0_last_row > q_r.region1_last_row) ?
                 q_r.region0_last_row : q_r.region1_last_row;
      in0 = in_rows(q_r.row, q_r.region0_first_row, q_r.region0_last_row);
      in1 = in_rows(q_r.row, q_r.region1_first_row, q_r.region1_last_row);

      // APB: one wait state, answer registered.
      q_nxt.pready = psel & penable & ~q_r.pready;
      q_nxt.pslverr = 1'b0;
      if (psel && penable && !q_r.pready) begin
         q_nxt.pslverr = ~rd_ok;
         q_nxt.prdata = pwrite ? '0 : rd_word;
      end
      if (psel && penable && q_r.pready && pwrite && !q_r.pslverr) begin
         if (paddr == ADDR_CTRL) begin
            q_nxt.ctrl = pwdata[CTRL_W-1:0];
         end else if (paddr == ADDR_REGION0_ROWS) begin
            q_nxt.region0_first_row = pwdata[FIRST_LSB +: ROW_W];
            q_nxt.region0_last_row = pwdata[LAST_LSB +: ROW_W];
         end else if (paddr == ADDR_REGION1_ROWS) begin
            q_nxt.region1_first_row = pwdata[FIRST_LSB +: ROW_W];
            q_nxt.region1_last_row = pwdata[LAST_LSB +: ROW_W];
         end else if (paddr == ADDR_REGION0_COLS) begin
            q_nxt.x0_first = pwdata[FIRST_LSB +: KERN_W];
            q_nxt.x0_last = pwdata[LAST_LSB +: KERN_W];
         end else if (paddr == ADDR_REGION1_COLS) begin
            q_nxt.x1_first = pwdata[FIRST_LSB +: KERN_W];
            q_nxt.x1_last = pwdata[LAST_LSB +: KERN_W];
         end else if (paddr == ADDR_OVERHEAD) begin
            q_nxt.frame_overhead_time = pwdata[FIRST_LSB +: CNT_W];
            q_nxt.row_overhead_time = pwdata[LAST_LSB +: CNT_W];
         end else if (paddr == ADDR_BLACK_LINES) begin
            q_nxt.black_lines = pwdata[KERN_W-1:0];
         end else if (paddr == ADDR_TRAINING) begin
            q_nxt.train = pwdata[PIX_W-1:0];
         end
      end

      // Frame engine: one output word per link clock cycle.
      if (step) begin
         q_nxt.fv = ~q_r.blk | q_r.f_bf;
         q_nxt.lv = 1'b0;
         q_nxt.dout = q_r.train;
         case (q_r.st)
            ST_IDLE: begin
               q_nxt.fv = 1'b0;
               if (q_r.ctrl[CTRL_ENABLE]) begin
                  q_nxt.st = ST_FOT;
                  q_nxt.cnt = '0;
                  q_nxt.f_sub = q_r.ctrl[CTRL_SUBSAMPLE];
                  q_nxt.f_col = q_r.ctrl[CTRL_COLOUR];
                  q_nxt.f_seed = q_r.ctrl[CTRL_CRC_SEED];
                  q_nxt.f_bf = q_r.ctrl[CTRL_BLACK_ROW_FRAME_FLAG_ON];
                  q_nxt.f_bl = q_r.ctrl[CTRL_BLACK_ROW_ROW_FLAG_ON];
                  q_nxt.blk = (q_r.black_lines != '0);
                  q_nxt.blk_idx = '0;
                  q_nxt.row = first_all;
                  // The strobe stays low for this word so every frame ends with a fall.
               end
            end
            ST_FOT: begin
               if (count_done(q_r.cnt, q_r.frame_overhead_time)) begin
                  q_nxt.st = ST_ROT;
                  q_nxt.cnt = '0;
               end else begin
                  q_nxt.cnt = q_r.cnt + 16'h0001;
               end
            end
            ST_ROT: begin
               if (!count_done(q_r.cnt, q_r.row_overhead_time)) begin
                  q_nxt.cnt = q_r.cnt + 16'h0001;
               end else if (q_r.blk || in0 || in1) begin
                  q_nxt.st = ST_PIX;
                  q_nxt.seg = ~q_r.blk & ~in0;
                  q_nxt.kern = (!q_r.blk && !in0) ? q_r.x1_first : q_r.x0_first;
                  q_nxt.sub = '0;
                  crc_init = 1'b1;
               end else begin
                  q_nxt.cnt = '0;
                  if (q_r.row >= last_all) begin
                     q_nxt.st = ST_IDLE;
                  end else begin
                     q_nxt.row = q_r.row + 11'h001;
                  end
               end
            end
            ST_PIX: begin
               q_nxt.dout = pix_data;
               q_nxt.lv = ~q_r.blk | q_r.f_bl;
               crc_upd = 1'b1;
               q_nxt.sub = q_r.sub + 3'h1;
               if (q_r.sub == KERNEL_LAST) begin
                  next_kern = {1'b0, q_r.kern} + (q_r.f_sub ? 9'h002 : 9'h001);
                  seg_last = q_r.seg ? q_r.x1_last : q_r.x0_last;
                  if (next_kern <= {1'b0, seg_last}) begin
                     q_nxt.kern = next_kern[KERN_W-1:0];
                  end else if (!q_r.seg && !q_r.blk && in1) begin
                     q_nxt.seg = 1'b1;
                     q_nxt.kern = q_r.x1_first;
                  end else begin
                     q_nxt.st = ST_CRC;
                  end
               end
            end
            ST_CRC: begin
               q_nxt.dout = crc_val;
               q_nxt.st = ST_ROT;
               q_nxt.cnt = '0;
               if (q_r.blk) begin
                  if ({1'b0, q_r.blk_idx} + 9'h001 >= {1'b0, q_r.black_lines}) begin
                     q_nxt.blk = 1'b0;
                  end else begin
                     q_nxt.blk_idx = q_r.blk_idx + 8'h01;
                  end
               end else if (q_r.row >= last_all) begin
                  q_nxt.st = ST_IDLE;
                  q_nxt.frames = q_r.frames + 16'h0001;
               end else begin
                  q_nxt.row = q_r.row + 11'h001;
               end
            end
            default: begin
               q_nxt.st = ST_IDLE;
            end
         endcase
      end

      // Address of the next pixel for the array.
      q_nxt.pblk = q_r.blk;
      q_nxt.prow = q_r.blk ? {3'h0, q_r.blk_idx} : q_r.row;
      q_nxt.pcol = {1'b0, q_r.kern, 3'h0} +
                   {8'h00, pix_off(q_r.sub, q_r.kern[0], q_r.f_sub, q_r.f_col)};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= CORE_RESET;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata = q_r.prdata;
   assign pready = q_r.pready;
   assign pslverr = q_r.pslverr;
   assign pix_row = q_r.prow;
   assign pix_col = q_r.pcol;
   assign pix_black = q_r.pblk;
   assign out_clk = q_r.clk_out;
   assign frame_strobe = q_r.fv;
   assign row_strobe = q_r.lv;
   assign out_data = q_r.dout;

endmodule

// ==== sim/pixel_out_assertions.sv ====
module pixel_out_assertions
   import pixel_out_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Link and output.
   input wire logic link_clk,
   input wire logic out_clk,
   input wire logic frame_strobe,
   input wire logic row_strobe,
   input wire logic [PIX_W-1:0] out_data
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_data_step;
      $changed(out_data) |-> $fell(out_clk);
   endproperty
   a_data_step: assert property (p_data_step)
      else $error("Output word moved off a clock fall.");
   property p_strobe_step;
      $changed({frame_strobe, row_strobe}) |-> $fell(out_clk);
   endproperty
   a_strobe_step: assert property (p_strobe_step)
      else $error("Strobe moved off a clock fall.");
   property p_clk_follow;
      $fell(link_clk) |-> ##[1:6] !out_clk;
   endproperty
   a_clk_follow: assert property (p_clk_follow)
      else $error("Output clock did not follow the link clock.");
   property p_clk_half;
      $fell(out_clk) |=> !out_clk [*5];
   endproperty
   a_clk_half: assert property (p_clk_half)
      else $error("Output clock low phase too short.");
   property p_row_hold;
      $rose(row_strobe) |=> row_strobe [*8];
   endproperty
   a_row_hold: assert property (p_row_hold)
      else $error("Row strobe shorter than one word.");
   property p_crc_low;
      $fell(row_strobe) |=> !row_strobe [*8];
   endproperty
   a_crc_low: assert property (p_crc_low)
      else $error("Row strobe back during the check word.");
   property p_frame_rise;
      $rose(frame_strobe) |-> !row_strobe;
   endproperty
   a_frame_rise: assert property (p_frame_rise)
      else $error("Frame strobe rose inside a line.");
   property p_frame_fall;
      $fell(frame_strobe) |-> !row_strobe && !$past(row_strobe);
   endproperty
   a_frame_fall: assert property (p_frame_fall)
      else $error("Frame strobe fell before the line ended.");
   property p_apb_wait;
      psel && penable && !$past(penable) |-> !pready ##1 pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("Bus answer not in the second access cycle.");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err)
      else $error("Error flag without ready.");
   c_frame: cover property ($rose(frame_strobe));
   c_row: cover property ($rose(row_strobe));
   c_err: cover property (pslverr);
endmodule

bind pixel_out pixel_out_assertions pixel_out_assertions_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
   .out_clk(out_clk), .frame_strobe(frame_strobe), .row_strobe(row_strobe),
   .out_data(out_data));

// ==== sim/pixel_capture.sv ====
module pixel_capture
   import pixel_out_pkg::*;
(
   // Output link of the sensor.
   input wire logic out_clk,
   input wire logic frame_strobe,
   input wire logic row_strobe,
   input wire logic [PIX_W-1:0] out_data,
   // Line check seed.
   input wire logic seed_ones
);
   timeunit 1ns;
   timeprecision 100ps;
   logic fs_q = 1'b0;
   logic rs_q = 1'b0;
   logic [PIX_W-1:0] crc = '0;
   logic [PIX_W-1:0] cur[$];
   logic [PIX_W-1:0] s_line[$];
   logic [PIX_W-1:0] firsts[$];
   logic [PIX_W-1:0] s_firsts[$];
   int lens[$];
   int s_lens[$];
   int rs_in = 0, rs_out = 0, words = 0, bad = 0, blk0 = 0, fblk = 0, frames = 0;
   int s_in, s_out, s_words, s_bad, s_blk0, s_fblk;

   function automatic logic [PIX_W-1:0] crc_step(input logic [PIX_W-1:0] c,
                                                 input logic [PIX_W-1:0] d);
      logic fb;
      for (int i = PIX_W - 1; i >= 0; i--) begin
         fb = c[PIX_W-1] ^ d[i];
         c = {c[PIX_W-2:0], 1'b0};
         if (fb) c = c ^ CRC_POLY;
      end
      return c;
   endfunction

   // Data and both strobes are taken together on the rising output clock.
   always @(posedge out_clk) begin
      if (row_strobe) begin
         if (!rs_q) begin
            crc = seed_ones ? '1 : '0;
            cur.delete();
            firsts.push_back(out_data);
         end
         crc = crc_step(crc, out_data);
         cur.push_back(out_data);
         words += frame_strobe;
      end else if (rs_q) begin
         bad += (out_data !== crc);
         lens.push_back(cur.size());
         if (frame_strobe) rs_in++;
         else rs_out++;
      end
      blk0 += (out_data === 10'h200);
      fblk += (out_data === 10'h200) && frame_strobe;
      if (fs_q && !frame_strobe) begin
         s_in = rs_in;
         s_out = rs_out;
         s_words = words;
         s_bad = bad;
         s_blk0 = blk0;
         s_fblk = fblk;
         s_lens = lens;
         s_firsts = firsts;
         s_line = cur;
         {rs_in, rs_out, words, bad, blk0, fblk} = '0;
         lens.delete();
         firsts.delete();
         frames++;
      end
      fs_q = frame_strobe;
      rs_q = row_strobe;
   end
endmodule

// ==== sim/parallel_pixel_output_framing_tb_top.sv ====
module parallel_pixel_output_framing_tb_top
   import pixel_out_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 90000;
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [7:0] rs_in;
      logic [7:0] rs_out;
      logic [15:0] words;
      logic [7:0] fblk;
   } frame_case_t;
   frame_case_t cases [4] = '{'{6'h31, 8'h11, 8'h00, 16'h0160, 8'h01},
      '{6'h11, 8'h0F, 8'h00, 16'h0140, 8'h01}, '{6'h21, 8'h0F, 8'h02, 16'h0140, 8'h00},
      '{6'h01, 8'h0F, 8'h00, 16'h0140, 8'h00}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_clk, seed_ones;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [ROW_W-1:0] pix_row;
   logic [COL_W-1:0] pix_col;
   logic pix_black, out_clk, frame_strobe, row_strobe;
   logic [PIX_W-1:0] pix_data, out_data;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;

   pixel_out pixel_out_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .pix_row(pix_row), .pix_col(pix_col),
      .pix_black(pix_black), .pix_data(pix_data), .out_clk(out_clk),
      .frame_strobe(frame_strobe), .row_strobe(row_strobe), .out_data(out_data));
   pixel_capture pixel_capture_i (.out_clk(out_clk), .frame_strobe(frame_strobe),
      .row_strobe(row_strobe), .out_data(out_data), .seed_ones(seed_ones));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      link_clk = 1'b0;
      forever #32 link_clk = ~link_clk;
   end
   // The pixel array answers with black flag, low row bits and column.
   always @(posedge pclk) pix_data <= {pix_black, pix_row[2:0], pix_col[5:0]};
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x,
                         input logic xe);
      logic [DATA_W-1:0] q;
      logic e;
      apb(1'b0, a, '0, q, e);
      check(q, x);
      check({31'h0, e}, {31'h0, xe});
   endtask

   // The first frame end after a change may still use the old settings.
   task automatic frame_pair();
      int n;
      repeat (2) begin
         n = pixel_capture_i.frames;
         wait (pixel_capture_i.frames != n);
      end
   endtask

   function automatic logic [31:0] exp_col(input int m, input int i);
      int g = i / 8;
      int p = i % 8;
      if (m == 0) return 32'(8 * g + ((g % 2 == 1) ? 7 - p : p));
      if (m == 1) return 32'(16 * g + 2 * p);
      return 32'(16 * g + 4 * (p / 2) + p % 2);
   endfunction

   initial begin
      logic [CTRL_W-1:0] c;
      int img;
      {psel, penable, pwrite, seed_ones, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      pix_data = '0;
      do_reset();
      foreach (cases[i]) begin
         wr(ADDR_CTRL, {26'h0, cases[i].ctrl});
         frame_pair();
         check(pixel_capture_i.s_in, cases[i].rs_in);
         check(pixel_capture_i.s_out, cases[i].rs_out);
         check(pixel_capture_i.s_fblk, cases[i].fblk);
         check(pixel_capture_i.s_blk0, 32'h1);
         check(pixel_capture_i.s_words, cases[i].words);
         check(pixel_capture_i.s_bad, 32'h0);
         img = 0;
         foreach (pixel_capture_i.s_lens[j]) begin
            if (pixel_capture_i.s_firsts[j][9] === 1'b1) begin
               check(pixel_capture_i.s_lens[j], 32'h10);
            end else begin
               check(pixel_capture_i.s_lens[j], (img >= 5 && img <= 9) ? 32'h20 : 32'h10);
               check(pixel_capture_i.s_firsts[j][8:6], img[2:0]);
               img++;
            end
         end
         check(img, 32'hF);
      end
      do_reset();
      rd_chk(ADDR_CTRL, 32'h0000_0030, 1'b0);
      rd_chk(ADDR_REGION1_ROWS, 32'h000E_0005, 1'b0);
      rd_chk(ADDR_OVERHEAD, 32'h0004_0008, 1'b0);
      rd_chk(ADDR_TRAINING, 32'h0000_03A6, 1'b0);
      rd_chk(8'h24, 32'h0, 1'b1);
      wr(ADDR_BLACK_LINES, 32'h0);
      wr(ADDR_REGION0_ROWS, 32'h0);
      wr(ADDR_REGION1_ROWS, 32'h0);
      for (int m = 0; m < 3; m++) begin
         c = 6'h01;
         c[CTRL_SUBSAMPLE] = (m > 0);
         c[CTRL_COLOUR] = (m == 2);
         c[CTRL_CRC_SEED] = (m == 1);
         seed_ones <= c[CTRL_CRC_SEED];
         wr(ADDR_CTRL, {26'h0, c});
         frame_pair();
         check(pixel_capture_i.s_line.size(), (m == 0) ? 32'h20 : 32'h10);
         foreach (pixel_capture_i.s_line[j]) begin
            check(pixel_capture_i.s_line[j], exp_col(m, j));
         end
         check(pixel_capture_i.s_bad, 32'h0);
      end
      summarize();
   end
endmodule
